// ---- rtl/ctu_pkg.sv ----
// Purpose: Constants and types shared by the compare timer unit
// Assumes: One 10 MHz clock, synchronous active-high reset
// Notes: Functional notes follow
//
// Functional notes
// - Period compare zero: match every clock
// - Period FFFFH wraps to zero, no wrap flag
// - Period compare writes reach buffer immediately
// - Channel compare below period toggles once per period
// - Channel compare above period never matches
// - Channel buffers load and match in both modes
// - Period and channel at one toggle every two
// - Mode 001 counts only valid input edges
// - Event start clears counter, loads period buffer
// - Event match clears counter, raises period irq
// - Event irq every period plus one edges
// - Outputs unavailable in event count mode
// - Event pin only count clock, capture edge 00
// - Mode 000 start clears, toggles, loads buffer
// - Stopped counter holds FFFFH, reads zero
// - Interval match clears, toggles, raises irq
package ctu_pkg;
  localparam int CTU_W = 16;
  localparam logic [15:0] CTU_CNT_STOP = 16'hFFFF;
  localparam logic [15:0] CTU_CNT_ZERO = 16'h0000;
  localparam logic [2:0] CTU_MODE_INTERVAL = 3'h0;
  localparam logic [2:0] CTU_MODE_EVENT = 3'h1;
  localparam logic [1:0] CTU_EDGE_NONE = 2'h0;
  localparam logic [1:0] CTU_EDGE_RISE = 2'h1;
  localparam logic [1:0] CTU_EDGE_FALL = 2'h2;
  localparam logic [1:0] CTU_EDGE_BOTH = 2'h3;
  localparam logic [3:0] CTU_OUT_RESET = 4'h0;
  localparam logic [3:0] CTU_IRQ_RESET = 4'h0;
  typedef enum logic [1:0] {CTU_IDLE, CTU_WAIT_EDGE, CTU_RUN} ctu_state_e;
endpackage

// ---- rtl/ctu_edge_if.sv ----
// Purpose: Carries the qualified count enable from edge detector to core
// Assumes: Single clock domain
// Notes: Detector drives tick and core reads it; core drives edge_sel
interface ctu_edge_if;
  logic [1:0] edge_sel;
  logic tick;
  modport det (input edge_sel, output tick);
  modport core (output edge_sel, input tick);
endinterface

// ---- rtl/ctu_edge_det.sv ----
// Purpose: Synchronise the event pin and detect the selected edge
// Assumes: Pin is asynchronous to clk_sys
// Notes: Pulse is one clk_sys cycle per valid edge
module ctu_edge_det (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic event_input_pin,
  ctu_edge_if.det eif
);
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic tick_reg;
  logic rise;
  logic fall;

  // =====================================================================
  // Synchroniser, first stage feeds only the second
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= event_input_pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  // =====================================================================
  // Edge polarity selection
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      tick_reg <= 1'b0;
    else
    begin
      case (eif.edge_sel)
        ctu_pkg::CTU_EDGE_RISE: tick_reg <= rise;
        ctu_pkg::CTU_EDGE_FALL: tick_reg <= fall;
        ctu_pkg::CTU_EDGE_BOTH: tick_reg <= rise | fall;
        default: tick_reg <= 1'b0;
      endcase
    end
  end

  assign eif.tick = tick_reg;

  property p_tick_rise;
    @(posedge clk_sys) disable iff (srst)
      (eif.edge_sel == ctu_pkg::CTU_EDGE_RISE && rise) |=> tick_reg;
  endproperty
  a_tick_rise: assert property (p_tick_rise)
    else $error("rising edge not counted");
  property p_tick_none;
    @(posedge clk_sys) disable iff (srst)
      $past(eif.edge_sel) == ctu_pkg::CTU_EDGE_NONE |-> !tick_reg;
  endproperty
  a_tick_none: assert property (p_tick_none)
    else $error("tick without edge selection");
endmodule // ctu_edge_det

// ---- rtl/ctu_timer.sv ----
// Purpose: 16-bit interval and event count timer with four compare channels
// Assumes: Count clock is clk_sys in interval mode unless event counting enabled
// Notes: Control bits are plain ports; match irqs are high one cycle per hit, so steady at period zero; wrap_irq stays low
module ctu_timer (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic run_bit,
  input wire logic [2:0] mode_select_field,
  input wire logic event_count_enable_bit,
  input wire logic [1:0] event_edge_select,
  input wire logic [1:0] capture_edge_select,
  input wire logic [15:0] period_compare_reg,
  input wire logic [15:0] chan1_compare_reg,
  input wire logic [15:0] chan2_compare_reg,
  input wire logic [15:0] chan3_compare_reg,
  input wire logic [3:0] out_enable,
  input wire logic [3:0] out_disabled_level,
  input wire logic event_input_pin,
  output logic [15:0] count_read_reg,
  output logic period_match_irq,
  output logic [2:0] chan_k_match_irq,
  output logic [3:0] toggle_out,
  output logic wrap_flag,
  output logic wrap_irq
);
  ctu_edge_if eif ();
  ctu_pkg::ctu_state_e state_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] buf_reg [4];
  logic [3:0] tog_reg;
  logic [3:0] match_irq_reg;
  logic [15:0] count_read_next;
  logic run_d_reg;
  logic start;
  logic event_mode;
  logic ext_clk;
  logic cnt_tick;
  logic [3:0] hit;
  logic [15:0] cmp_src [4];

  ctu_edge_det u_edge (
    .clk_sys(clk_sys),
    .srst(srst),
    .event_input_pin(event_input_pin),
    .eif(eif)
  );

  // The capture edge field must be 00 when the pin clocks the counter, so edge
  // selection is forced off otherwise to keep the pin single-use.
  assign eif.edge_sel = (capture_edge_select == ctu_pkg::CTU_EDGE_NONE) ?
    event_edge_select : ctu_pkg::CTU_EDGE_NONE;

  assign event_mode = (mode_select_field == ctu_pkg::CTU_MODE_EVENT);
  assign ext_clk = event_mode |
    ((mode_select_field == ctu_pkg::CTU_MODE_INTERVAL) & event_count_enable_bit);
  assign cnt_tick = ext_clk ? eif.tick : 1'b1;
  assign start = run_bit & ~run_d_reg;
  assign cmp_src[0] = period_compare_reg;
  assign cmp_src[1] = chan1_compare_reg;
  assign cmp_src[2] = chan2_compare_reg;
  assign cmp_src[3] = chan3_compare_reg;

  // =====================================================================
  // Run edge and start sequencing
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      run_d_reg <= 1'b0;
    else
      run_d_reg <= run_bit;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      state_reg <= ctu_pkg::CTU_IDLE;
    else
    begin
      case (state_reg)
        ctu_pkg::CTU_IDLE:
          if (start)
            state_reg <= ctu_pkg::CTU_WAIT_EDGE;
        ctu_pkg::CTU_WAIT_EDGE:
          if (!run_bit)
            state_reg <= ctu_pkg::CTU_IDLE;
          else if (cnt_tick)
            state_reg <= ctu_pkg::CTU_RUN;
        ctu_pkg::CTU_RUN:
          if (!run_bit)
            state_reg <= ctu_pkg::CTU_IDLE;
        default: state_reg <= ctu_pkg::CTU_IDLE;
      endcase
    end
  end

  // =====================================================================
  // Compare buffers: anytime write, buffers follow registers every clock, running or stopped
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < 4; i++)
        buf_reg[i] <= ctu_pkg::CTU_CNT_ZERO;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        buf_reg[i] <= cmp_src[i];
    end
  end

  // =====================================================================
  // Counter: first tick after start takes FFFFH to 0000H
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_hit
      assign hit[g] = (state_reg == ctu_pkg::CTU_RUN) & cnt_tick &
        (cnt_reg == buf_reg[g]);
    end
  endgenerate

  always_comb
  begin
    cnt_next = cnt_reg;
    if (!run_bit)
      cnt_next = ctu_pkg::CTU_CNT_STOP;
    else if (state_reg == ctu_pkg::CTU_WAIT_EDGE && cnt_tick)
      cnt_next = ctu_pkg::CTU_CNT_ZERO;
    else if (hit[0])
      cnt_next = ctu_pkg::CTU_CNT_ZERO;
    else if (state_reg == ctu_pkg::CTU_RUN && cnt_tick)
      cnt_next = cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cnt_reg <= ctu_pkg::CTU_CNT_STOP;
    else
      cnt_reg <= cnt_next;
  end

  assign count_read_next = run_bit ? cnt_next : ctu_pkg::CTU_CNT_ZERO;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      count_read_reg <= ctu_pkg::CTU_CNT_ZERO;
    else
      count_read_reg <= count_read_next;
  end

  // =====================================================================
  // Match interrupts, high one cycle per hit, so held high while hitting every clock
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      match_irq_reg <= ctu_pkg::CTU_IRQ_RESET;
    else
      match_irq_reg <= hit;
  end

  // A count past FFFFH rolls over to 0000H by plain overflow, and wrap_flag and wrap_irq are held low;
  // overflow handling belongs to modes not built here.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      wrap_flag <= 1'b0;
      wrap_irq <= 1'b0;
    end
    else
    begin
      wrap_flag <= 1'b0;
      wrap_irq <= 1'b0;
    end
  end

  // =====================================================================
  // Toggle outputs
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      tog_reg <= ctu_pkg::CTU_OUT_RESET;
    else if (!run_bit || event_mode)
      tog_reg <= out_disabled_level;
    else
    begin
      if ((state_reg == ctu_pkg::CTU_WAIT_EDGE && cnt_tick) || hit[0])
        tog_reg[0] <= ~tog_reg[0];
      for (int k = 1; k < 4; k++)
        if (hit[k])
          tog_reg[k] <= ~tog_reg[k];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      toggle_out <= ctu_pkg::CTU_OUT_RESET;
    else
      toggle_out <= (tog_reg & out_enable) | (out_disabled_level & ~out_enable) ;
  end

  assign period_match_irq = match_irq_reg[0];
  assign chan_k_match_irq = match_irq_reg[3:1];

  // =====================================================================
  // Checks
  property p_stop_hold;
    @(posedge clk_sys) disable iff (srst)
      !run_bit |=> cnt_reg == ctu_pkg::CTU_CNT_STOP && count_read_reg == ctu_pkg::CTU_CNT_ZERO;
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("stopped counter not held");
  property p_stop_hold_chk;
    @(posedge clk_sys) disable iff (srst)
      !run_bit |=> cnt_reg == ctu_pkg::CTU_CNT_STOP;
  endproperty
  a_stop_hold_chk: assert property (p_stop_hold_chk)
    else $error("stopped counter left its full count");
  property p_zero_period;
    @(posedge clk_sys) disable iff (srst)
      (state_reg == ctu_pkg::CTU_RUN && !ext_clk && buf_reg[0] == 16'h0000 && run_bit && cnt_reg == 16'h0000
       && $stable(buf_reg[0])) |=> period_match_irq && cnt_reg == 16'h0000;
  endproperty
  a_zero_period: assert property (p_zero_period)
    else $error("zero period not matching each clock");
  property p_match_clear;
    @(posedge clk_sys) disable iff (srst)
      (hit[0] && run_bit) |=> cnt_reg == 16'h0000 && period_match_irq;
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("period match did not clear");
  property p_start_clear;
    @(posedge clk_sys) disable iff (srst)
      (state_reg == ctu_pkg::CTU_WAIT_EDGE && cnt_tick && run_bit) |=> cnt_reg == 16'h0000;
  endproperty
  a_start_clear: assert property (p_start_clear)
    else $error("start did not clear counter");
  property p_no_wrap;
    @(posedge clk_sys) disable iff (srst)
      ##1 !wrap_flag && !wrap_irq;
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("wrap raised");
  // While running outside event mode, channel toggle bit k moves only on the edge after its own hit, so the hit is tested in the cycle before
  property p_chan_far;
    @(posedge clk_sys) disable iff (srst)
      (run_bit && !event_mode && !hit[1]) |=> $stable(tog_reg[1]);
  endproperty
  a_chan_far: assert property (p_chan_far)
    else $error("channel 1 toggled without match");
  property p_event_out;
    @(posedge clk_sys) disable iff (srst)
      event_mode |=> tog_reg == $past(out_disabled_level);
  endproperty
  a_event_out: assert property (p_event_out)
    else $error("outputs active in event mode");
  property p_event_tick;
    @(posedge clk_sys) disable iff (srst)
      (event_mode && run_bit && state_reg == ctu_pkg::CTU_RUN && !eif.tick) |=> $stable(cnt_reg);
  endproperty
  a_event_tick: assert property (p_event_tick)
    else $error("event counter moved without edge");
  property p_stop_out;
    @(posedge clk_sys) disable iff (srst)
      !run_bit |=> tog_reg == $past(out_disabled_level);
  endproperty
  a_stop_out: assert property (p_stop_out)
    else $error("stopped outputs not at disabled level");
endmodule // ctu_timer

// ---- tb/ctu_event_src.sv ----
// Purpose: External event source driving the timer's event pin
// Assumes: Shares clk_sys with the bench
// Notes: Pin stands still while inactive
module ctu_event_src (
  input wire logic clk_sys,
  input wire logic active,
  input wire logic [7:0] half_gap,
  output logic event_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  initial event_input_pin = 1'b0;
  // ==========
  // Edge maker
  // Pin moves 30 ns after the edge so the synchroniser never races it
  always @(posedge clk_sys)
  begin
    if (!active)
      n = 0;
    else if (++n >= int'(half_gap))
    begin
      n = 0;
      event_input_pin <= #30 ~event_input_pin;
    end
  end
endmodule // ctu_event_src

// ---- tb/ctu_timer_bench.sv ----
// Purpose: Self-checking bench for ctu_timer
// Assumes: 10 MHz clk_sys, synchronous reset
// Notes: Row table first, then hand-written cases
module ctu_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [2:0] md;
    logic ee;
    logic [1:0] es;
    logic [1:0] cs;
    logic [15:0] p, c1, c2, c3;
    int hg, sp;
    logic [2:0] cm;
    logic [3:0] tg;
  } ctu_row_s;
  localparam logic [2:0] MI = ctu_pkg::CTU_MODE_INTERVAL;
  localparam logic [2:0] ME = ctu_pkg::CTU_MODE_EVENT;
  localparam logic [1:0] ER = ctu_pkg::CTU_EDGE_RISE;
  localparam logic [1:0] EF = ctu_pkg::CTU_EDGE_FALL;
  localparam logic [1:0] EB = ctu_pkg::CTU_EDGE_BOTH;
  localparam logic [1:0] EN = ctu_pkg::CTU_EDGE_NONE;
  // sp: cycles between period matches, 0 when none may come
  ctu_row_s rows [8] = '{
    '{MI, 1'b0, ER, 2'h0, 16'h0000, 16'h0000, 16'h0005, 16'h0005, 3, 1, 3'h1, 4'h3},
    '{MI, 1'b0, ER, 2'h0, 16'h000A, 16'h0004, 16'h000A, 16'h000B, 3, 11, 3'h3, 4'h7},
    '{ME, 1'b0, ER, 2'h0, 16'h0004, 16'h0002, 16'h0004, 16'h0009, 3, 30, 3'h3, 4'h0},
    '{ME, 1'b0, EB, 2'h0, 16'h0002, 16'h0001, 16'h0001, 16'h0001, 5, 15, 3'h7, 4'h0},
    '{ME, 1'b0, EF, 2'h0, 16'h0003, 16'h0003, 16'h0007, 16'h0002, 2, 16, 3'h5, 4'h0},
    '{MI, 1'b1, ER, 2'h0, 16'h0001, 16'h0001, 16'h0001, 16'h0001, 4, 16, 3'h7, 4'hF},
    '{ME, 1'b0, ER, 2'h1, 16'h0004, 16'h0001, 16'h0001, 16'h0001, 3, 0, 3'h0, 4'h0},
    '{ME, 1'b0, EN, 2'h0, 16'h0004, 16'h0001, 16'h0001, 16'h0001, 3, 0, 3'h0, 4'h0}};
  logic clk_sys, srst, run_bit, event_count_enable_bit, event_input_pin;
  logic [2:0] mode_select_field;
  logic [1:0] event_edge_select, capture_edge_select;
  logic [15:0] period_compare_reg, chan1_compare_reg, chan2_compare_reg, chan3_compare_reg;
  logic [3:0] out_enable, out_disabled_level, toggle_out;
  logic [15:0] count_read_reg;
  logic period_match_irq, wrap_flag, wrap_irq, src_on, wrap_seen;
  logic [2:0] chan_k_match_irq;
  logic [7:0] half_gap;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int n;
  int e;

  ctu_timer dut_u (.clk_sys, .srst, .run_bit, .mode_select_field, .event_count_enable_bit,
    .event_edge_select, .capture_edge_select, .period_compare_reg, .chan1_compare_reg,
    .chan2_compare_reg, .chan3_compare_reg, .out_enable, .out_disabled_level, .event_input_pin,
    .count_read_reg, .period_match_irq, .chan_k_match_irq, .toggle_out, .wrap_flag, .wrap_irq);
  ctu_event_src src_u (.clk_sys, .active(src_on), .half_gap, .event_input_pin);

  // ==========
  // Clock, timeout and monitors
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc >= 90000)
    begin
      n_errors++;
      tally_and_finish;
    end
  end
  always @(negedge clk_sys)
    if (!srst && (wrap_flag !== 1'b0 || wrap_irq !== 1'b0)) wrap_seen = 1'b1;

  // ==========
  // Tasks
  task tally_and_finish;
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_cnt(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      n_errors++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask
  task chk_rst;
    chk_val(count_read_reg, 16'h0000);
    chk_val({9'h000, toggle_out, chan_k_match_irq}, 16'h0000);
    chk_val({13'h0000, period_match_irq, wrap_flag, wrap_irq}, 16'h0000);
  endtask
  // Bounded wait; returns lim when no period match came
  task wait_irq(input int lim, output int k);
    k = 0;
    do
    begin
      @(negedge clk_sys);
      k++;
    end while (period_match_irq !== 1'b1 && k < lim);
  endtask
  task apply(input ctu_row_s r);
    @(posedge clk_sys);
    run_bit <= 1'b0;
    src_on <= 1'b0;
    mode_select_field <= r.md;
    event_count_enable_bit <= r.ee;
    event_edge_select <= r.es;
    capture_edge_select <= r.cs;
    period_compare_reg <= r.p;
    chan1_compare_reg <= r.c1;
    chan2_compare_reg <= r.c2;
    chan3_compare_reg <= r.c3;
    half_gap <= 8'(r.hg);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_val(count_read_reg, 16'h0000);
    chk_val(16'(toggle_out), 16'h000A);
    @(posedge clk_sys);
    run_bit <= 1'b1;
    src_on <= 1'b1;
  endtask
  // Window of three periods: every periodic signal shows exactly three events
  task window(input ctu_row_s r);
    int pc;
    int cc [3];
    int tc [4];
    logic [3:0] tp;
    pc = 0;
    cc = '{0, 0, 0};
    tc = '{0, 0, 0, 0};
    tp = toggle_out;
    repeat (3 * r.sp)
    begin
      @(negedge clk_sys);
      pc += int'(period_match_irq === 1'b1);
      for (int k = 0; k < 4; k++)
      begin
        if (k < 3) cc[k] += int'(chan_k_match_irq[k] === 1'b1);
        tc[k] += int'(toggle_out[k] !== tp[k]);
      end
      tp = toggle_out;
    end
    chk_cnt(pc, 3);
    for (int k = 0; k < 3; k++) chk_cnt(cc[k], r.cm[k] ? 3 : 0);
    for (int k = 0; k < 4; k++) chk_cnt(tc[k], r.tg[k] ? 3 : 0);
  endtask

  // ==========
  // Main sequence
  initial
  begin
    srst = 1'b1;
    run_bit = 1'b0;
    src_on = 1'b0;
    wrap_seen = 1'b0;
    mode_select_field = MI;
    event_count_enable_bit = 1'b0;
    event_edge_select = ER;
    capture_edge_select = 2'h0;
    period_compare_reg = 16'h0000;
    chan1_compare_reg = 16'h0000;
    chan2_compare_reg = 16'h0000;
    chan3_compare_reg = 16'h0000;
    out_enable = 4'hF;
    out_disabled_level = 4'hA;
    half_gap = 8'h03;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_rst;
    @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      apply(rows[i]);
      wait_irq(400, n);
      if (rows[i].sp == 0)
        chk_cnt(n, 400);
      else
      begin
        wait_irq(400, n);
        chk_cnt(n, rows[i].sp);
        window(rows[i]);
      end
    end
    // Lowering the period below the live count forces a full wrap; output 0 is disabled meanwhile
    @(posedge clk_sys);
    out_enable <= 4'hE;
    apply('{MI, 1'b0, ER, 2'h0, 16'h0040, 16'hFFFF, 16'hFFFF, 16'hFFFF, 3, 0, 3'h0, 4'h0});
    wait_irq(400, n);
    repeat (48) @(negedge clk_sys);
    e = 32'h00010011 - int'(count_read_reg);
    @(posedge clk_sys);
    period_compare_reg <= 16'h0010;
    wait_irq(70000, n);
    chk_cnt(int'(n >= e - 3 && n <= e + 3), 1);
    chk_cnt(int'(wrap_seen), 0);
    // Third toggle of output 0 would show now if the enable were ignored
    @(negedge clk_sys);
    chk_val(16'(toggle_out[0]), 16'h0000);
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk_rst;
    tally_and_finish;
  end
endmodule // ctu_timer_bench
